// File: rtl/gated_16bit_timer.sv
`timescale 1ns/1ps
`include "gated_timer_consts.svh"
module gated_16bit_timer (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [`ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // gate sources
  input wire gated_timer_pkg::gate_inputs_s gateInputs,
  input wire logic [7:0] eightBitTimerCount,
  // count clock pins
  input wire logic externalClockPin,
  input wire logic crystalInputPin,
  output logic crystalOutputPin,
  // system
  input wire logic sleepMode,
  input wire logic captureEvent,
  input wire logic autoConversionTrigger,
  // status outputs
  output logic [15:0] countRegister,
  output logic compareMatch,
  output logic overflowIrq,
  output logic gateEventIrq,
  output logic wakeRequest
);
  import gated_timer_pkg::*;

  // =====================================================
  // registers
  timer_control_s ctrlQ;
  gate_control_s gctlQ;
  logic [3:0] enablesQ;
  logic overflowFlagQ, gateEventFlagQ;
  logic [15:0] countQ, countD;
  logic [15:0] captureCompareQ;
  logic waitQ;
  logic [31:0] rdataQ;

  // =====================================================
  // bus decode
  logic busReq, busFire, wrFire;
  logic selCtrl, selGate, selLow, selHigh, selFlags, selEn, selCc;
  assign busReq = read | write;
  assign busFire = busReq & ~waitQ;
  assign wrFire = write & ~waitQ;
  assign selCtrl = address == `OFF_TIMER_CONTROL;
  assign selGate = address == `OFF_GATE_CONTROL;
  assign selLow = address == `OFF_COUNT_LOW;
  assign selHigh = address == `OFF_COUNT_HIGH;
  assign selFlags = address == `OFF_FLAGS;
  assign selEn = address == `OFF_ENABLES;
  assign selCc = address == `OFF_CAPTURE_COMPARE;

  logic wrCtrl, wrGate, wrLow, wrHigh, wrFlags, wrEn, wrCc, wrCount;
  assign wrCtrl = wrFire & selCtrl;
  assign wrGate = wrFire & selGate;
  assign wrLow = wrFire & selLow;
  assign wrHigh = wrFire & selHigh;
  assign wrFlags = wrFire & selFlags;
  assign wrEn = wrFire & selEn;
  assign wrCc = wrFire & selCc;
  assign wrCount = wrLow | wrHigh;

  gate_control_s gateWr;
  assign gateWr = gate_control_s'(writedata[7:0]);

  logic [31:0] rdataD;
  assign rdataD = selCtrl ? {24'h00_0000, ctrlQ[7:2], 1'b0, ctrlQ.timerRunEnable} :
                  selGate ? {24'h00_0000, gctlQ} :
                  selLow ? {24'h00_0000, countQ[7:0]} :
                  selHigh ? {24'h00_0000, countQ[15:8]} :
                  selFlags ? {30'h0000_0000, gateEventFlagQ, overflowFlagQ} :
                  selEn ? {28'h000_0000, enablesQ} :
                  selCc ? {16'h0000, captureCompareQ} :
                  32'h0000_0000;

  // one wait cycle, then answer
  always_ff @(posedge clk) begin
    if (reset) begin
      waitQ <= 1'b1;
      rdataQ <= 32'h0000_0000;
    end else begin
      waitQ <= ~(busReq & waitQ);
      if (busReq & waitQ) begin
        rdataQ <= read ? rdataD : 32'h0000_0000;
      end
    end
  end

  // =====================================================
  // count clock selection
  logic [1:0] instrDivQ;
  logic instrTick;
  logic extSync1Q, extSync2Q;
  logic pinOrCrystal, extLevel, extRise;
  logic asyncMode, srcTick;

  assign instrTick = instrDivQ == `INSTR_DIV_LAST;
  assign pinOrCrystal = ctrlQ.secondaryOscEnable ? crystalInputPin : externalClockPin;
  assign extLevel = ctrlQ.syncBypass ? pinOrCrystal : extSync2Q;
  assign asyncMode = ctrlQ.clockSource == CLK_EXTERNAL && ctrlQ.syncBypass;

  always_ff @(posedge clk) begin
    if (reset) begin
      instrDivQ <= 2'h0;
      extSync1Q <= 1'b0;
      extSync2Q <= 1'b0;
      crystalOutputPin <= 1'b0;
    end else begin
      instrDivQ <= instrDivQ + 2'h1;
      extSync1Q <= pinOrCrystal;
      extSync2Q <= extSync1Q;
      crystalOutputPin <= ctrlQ.secondaryOscEnable & ~crystalInputPin;
    end
  end

  edge_sampler extEdge (
    .clk(clk),
    .reset(reset),
    .level(extLevel),
    .rise(extRise),
    .fall()
  );

  logic rawTick;
  always_comb begin
    unique case (ctrlQ.clockSource)
      CLK_INSTR: rawTick = instrTick;
      CLK_SYSTEM: rawTick = 1'b1;
      CLK_EXTERNAL: rawTick = extRise;
      CLK_RESERVED: rawTick = 1'b0;
    endcase
  end
  assign srcTick = rawTick & (~sleepMode | asyncMode);

  // =====================================================
  // prescaler
  logic [2:0] pscQ, pscLast;
  logic countTick;
  assign pscLast = 3'((4'h1 << ctrlQ.prescaleSelect) - 4'h1);
  assign countTick = srcTick & (pscQ == pscLast);

  always_ff @(posedge clk) begin
    if (reset || wrCount) begin
      pscQ <= 3'h0;
    end else if (srcTick) begin
      pscQ <= countTick ? 3'h0 : pscQ + 3'h1;
    end
  end

  // =====================================================
  // gate sources
  logic [7:0] eightPrevQ;
  logic eightOvfQ;
  logic compOneQ, compTwoQ;
  logic compOneSrc, compTwoSrc;

  always_ff @(posedge clk) begin
    if (reset) begin
      eightPrevQ <= 8'h00;
      eightOvfQ <= 1'b0;
      compOneQ <= 1'b0;
      compTwoQ <= 1'b0;
    end else begin
      eightPrevQ <= eightBitTimerCount;
      eightOvfQ <= eightPrevQ == `EIGHT_BIT_MAX && eightBitTimerCount == 8'h00;
      if (countTick) begin
        compOneQ <= gateInputs.comparatorOne;
        compTwoQ <= gateInputs.comparatorTwo;
      end
    end
  end

  assign compOneSrc = enablesQ[`EN_COMP_ONE_SYNC] ? compOneQ : gateInputs.comparatorOne;
  assign compTwoSrc = enablesQ[`EN_COMP_TWO_SYNC] ? compTwoQ : gateInputs.comparatorTwo;

  logic gateRaw;
  always_comb begin
    unique case (gctlQ.gateSourceSelect)
      GATE_PIN: gateRaw = gateInputs.gatePin;
      GATE_EIGHT_BIT_OVF: gateRaw = eightOvfQ;
      GATE_COMP_ONE: gateRaw = compOneSrc;
      GATE_COMP_TWO: gateRaw = compTwoSrc;
    endcase
  end

  // =====================================================
  // polarity and toggle
  logic gatePolarised, polRise, toggleQ, gateToggled;
  assign gatePolarised = gctlQ.gatePolarity ? gateRaw : ~gateRaw;

  edge_sampler polEdge (
    .clk(clk),
    .reset(reset),
    .level(gatePolarised),
    .rise(polRise),
    .fall()
  );

  always_ff @(posedge clk) begin
    if (reset || !gctlQ.gateToggleEnable || !ctrlQ.timerRunEnable) begin
      toggleQ <= 1'b0;
    end else if (polRise) begin
      toggleQ <= ~toggleQ;
    end
  end
  assign gateToggled = gctlQ.gateToggleEnable ? toggleQ : gatePolarised;

  // =====================================================
  // single pulse
  sp_state_e spQ, spD;
  logic tglRise, tglFall, spDone;

  edge_sampler tglEdge (
    .clk(clk),
    .reset(reset),
    .level(gateToggled),
    .rise(tglRise),
    .fall(tglFall)
  );

  always_comb begin
    spD = spQ;
    spDone = 1'b0;
    unique case (spQ)
      SP_IDLE: begin
        if (gctlQ.gateSinglePulseEnable && gctlQ.singlePulseArm) begin
          spD = SP_WAIT;
        end
      end
      SP_WAIT: begin
        if (!gctlQ.gateSinglePulseEnable || !gctlQ.singlePulseArm) begin
          spD = SP_IDLE;
        end else if (tglRise) begin
          spD = SP_COUNT;
        end
      end
      SP_COUNT: begin
        if (!gctlQ.gateSinglePulseEnable || !gctlQ.singlePulseArm) begin
          spD = SP_IDLE;
        end else if (tglFall) begin
          spD = SP_IDLE;
          spDone = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      spQ <= SP_IDLE;
    end else begin
      spQ <= spD;
    end
  end

  // idle after completion blocks gate until re-armed
  logic gateFinal;
  assign gateFinal = gctlQ.gateSinglePulseEnable ? (spQ == SP_COUNT) & gateToggled
                                                 : gateToggled;

  logic gvalFall;
  edge_sampler gvalEdge (
    .clk(clk),
    .reset(reset),
    .level(gctlQ.gateLevelStatus),
    .rise(),
    .fall(gvalFall)
  );

  // =====================================================
  // control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrlQ <= timer_control_s'(`TIMER_CONTROL_RESET);
      gctlQ <= gate_control_s'(`GATE_CONTROL_RESET);
      enablesQ <= 4'h0;
    end else begin
      if (wrCtrl) begin
        ctrlQ <= timer_control_s'(writedata[7:0]);
      end
      if (wrEn) begin
        enablesQ <= writedata[3:0];
      end
      if (wrGate) begin
        gctlQ.gateControlEnable <= gateWr.gateControlEnable;
        gctlQ.gatePolarity <= gateWr.gatePolarity;
        gctlQ.gateToggleEnable <= gateWr.gateToggleEnable;
        gctlQ.gateSinglePulseEnable <= gateWr.gateSinglePulseEnable;
        gctlQ.singlePulseArm <= gateWr.singlePulseArm;
        gctlQ.gateSourceSelect <= gateWr.gateSourceSelect;
      end else if (spDone) begin
        gctlQ.singlePulseArm <= 1'b0;
      end
      gctlQ.gateLevelStatus <= gateFinal;
    end
  end

  // =====================================================
  // counter
  logic countEnable, incr, wrap;
  assign countEnable = ctrlQ.timerRunEnable &
                       (~gctlQ.gateControlEnable | gctlQ.gateLevelStatus);
  assign incr = countTick & countEnable;
  assign wrap = incr & (countQ == `COUNT_MAX);

  always_comb begin
    countD = countQ;
    if (wrLow) begin
      countD[7:0] = writedata[7:0];
    end else if (wrHigh) begin
      countD[15:8] = writedata[7:0];
    end else if (autoConversionTrigger) begin
      countD = 16'h0000;
    end else if (incr) begin
      countD = countQ + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      countQ <= 16'h0000;
      captureCompareQ <= 16'h0000;
    end else begin
      countQ <= countD;
      if (captureEvent) begin
        captureCompareQ <= countQ;
      end else if (wrCc) begin
        captureCompareQ <= writedata[15:0];
      end
    end
  end

  // =====================================================
  // flags, set wins over clear
  logic ovfSet, gevSet;
  assign ovfSet = wrap & ~wrCount & ~autoConversionTrigger;
  assign gevSet = gvalFall;

  always_ff @(posedge clk) begin
    if (reset) begin
      overflowFlagQ <= 1'b0;
      gateEventFlagQ <= 1'b0;
    end else begin
      overflowFlagQ <= ovfSet | (overflowFlagQ & ~(wrFlags & writedata[`FLAG_OVERFLOW]));
      gateEventFlagQ <= gevSet |
                        (gateEventFlagQ & ~(wrFlags & writedata[`FLAG_GATE_EVENT]));
    end
  end

  // =====================================================
  // outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      countRegister <= 16'h0000;
      compareMatch <= 1'b0;
      overflowIrq <= 1'b0;
      gateEventIrq <= 1'b0;
      wakeRequest <= 1'b0;
    end else begin
      countRegister <= countD;
      compareMatch <= countD == captureCompareQ;
      overflowIrq <= overflowFlagQ & enablesQ[`EN_OVERFLOW_IRQ];
      gateEventIrq <= gateEventFlagQ & enablesQ[`EN_GATE_EVENT_IRQ];
      wakeRequest <= sleepMode & asyncMode & overflowFlagQ & enablesQ[`EN_OVERFLOW_IRQ];
    end
  end

  assign readdata = rdataQ;
  assign waitrequest = waitQ;
endmodule // gated_16bit_timer

// File: rtl/gated_timer_consts.svh
// Contract
// - two-bit code picks the gate source
// - eight-bit timer wrap gives one gate pulse
// - comparator sources optionally resynchronised to timer clock
// - toggle mode inverts on each rising gate edge
// - toggle flip-flop held clear while toggle off
// - armed single pulse counts from next rising edge
// - arm bit cleared on pulse trailing edge
// - gate events ignored until arm set again
// - toggle plus single pulse counts one cycle
// - gate level readable even with gating off
// - gate level falling edge sets gate event flag
// - count wrap sets overflow flag, software clears
// - sleep counting only asynchronous external, wakes
// - count feeds capture and compare
// - conversion trigger clears count without overflow flag
// - count byte write beats conversion trigger clear
// - control bits 7:6 select count clock
// - control bits 5:4 select prescale ratio
// - bit 3 picks crystal, bit 2 skips sync
// - bit 0 enables timer, clear resets toggle
// - count when enabled and gate active if gated
// - polarity one counts high, zero counts low
// - count byte write clears the prescale counter
`ifndef GATED_TIMER_CONSTS_SVH
`define GATED_TIMER_CONSTS_SVH

// =====================================================
// register byte addresses
`define ADDR_W 5
`define OFF_TIMER_CONTROL 5'h00
`define OFF_GATE_CONTROL 5'h04
`define OFF_COUNT_LOW 5'h08
`define OFF_COUNT_HIGH 5'h0c
`define OFF_FLAGS 5'h10
`define OFF_ENABLES 5'h14
`define OFF_CAPTURE_COMPARE 5'h18

// =====================================================
// reset values and field positions
`define TIMER_CONTROL_RESET 8'h00
`define GATE_CONTROL_RESET 8'h00
`define FLAG_OVERFLOW 0
`define FLAG_GATE_EVENT 1
`define EN_OVERFLOW_IRQ 0
`define EN_GATE_EVENT_IRQ 1
`define EN_COMP_ONE_SYNC 2
`define EN_COMP_TWO_SYNC 3
`define COUNT_MAX 16'hffff
`define EIGHT_BIT_MAX 8'hff
`define INSTR_DIV_LAST 2'h3

`endif

// File: rtl/gated_timer_pkg.sv
package gated_timer_pkg;

  typedef enum logic [1:0] {
    CLK_INSTR = 2'h0,
    CLK_SYSTEM = 2'h1,
    CLK_EXTERNAL = 2'h2,
    CLK_RESERVED = 2'h3
  } clk_src_e;

  typedef enum logic [1:0] {
    GATE_PIN = 2'h0,
    GATE_EIGHT_BIT_OVF = 2'h1,
    GATE_COMP_ONE = 2'h2,
    GATE_COMP_TWO = 2'h3
  } gate_src_e;

  typedef enum logic [1:0] {SP_IDLE, SP_WAIT, SP_COUNT} sp_state_e;

  typedef struct packed {
    clk_src_e clockSource;
    logic [1:0] prescaleSelect;
    logic secondaryOscEnable;
    logic syncBypass;
    logic unused;
    logic timerRunEnable;
  } timer_control_s;

  typedef struct packed {
    logic gateControlEnable;
    logic gatePolarity;
    logic gateToggleEnable;
    logic gateSinglePulseEnable;
    logic singlePulseArm;
    logic gateLevelStatus;
    gate_src_e gateSourceSelect;
  } gate_control_s;

  typedef struct packed {
    logic gatePin;
    logic comparatorOne;
    logic comparatorTwo;
  } gate_inputs_s;

endpackage

// File: rtl/edge_sampler.sv
`timescale 1ns/1ps
module edge_sampler (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // sampled level
  input wire logic level,
  // edge pulses
  output logic rise,
  output logic fall
);
  logic prevQ;

  always_ff @(posedge clk) begin
    if (reset) begin
      prevQ <= 1'b0;
    end else begin
      prevQ <= level;
    end
  end

  assign rise = level & ~prevQ;
  assign fall = ~level & prevQ;
endmodule // edge_sampler

// File: testbench/gated_16bit_timer_assertions.sv
`timescale 1ns/1ps
`include "gated_timer_consts.svh"
module gated_16bit_timer_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register bus
  input wire logic [`ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // pins and status
  input wire logic crystalInputPin,
  input wire logic crystalOutputPin,
  input wire logic sleepMode,
  input wire logic autoConversionTrigger,
  input wire logic [15:0] countRegister,
  input wire logic compareMatch,
  input wire logic overflowIrq,
  input wire logic wakeRequest
);
  // ========
  // bus, count and pin checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire logic taken = write && !waitrequest;
  waitOne_a: assert property (!waitrequest |=> waitrequest)
    else $error("wait low longer than one cycle");
  waitAnswer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered");
  unmappedRead_a: assert property (read && waitrequest && address > 5'h18 |=> readdata == 0)
    else $error("unmapped read not zero");
  crystalOut_a: assert property (crystalOutputPin |-> !$past(crystalInputPin))
    else $error("crystal output not inverted input");
  wakeSleep_a: assert property (wakeRequest |-> $past(sleepMode) && overflowIrq)
    else $error("wake without sleep or overflow");
  triggerClear_a: assert property (autoConversionTrigger && !taken |=> countRegister == 0)
    else $error("trigger did not clear count");
  writeWins_a: assert property (
    autoConversionTrigger && taken && address == `OFF_COUNT_LOW
      |=> countRegister[7:0] == $past(writedata[7:0]))
    else $error("count write lost to trigger");
  countStep_a: assert property (countRegister == $past(countRegister)
    || countRegister == 16'($past(countRegister) + 16'h0001)
    || countRegister == 16'h0000 || $past(taken))
    else $error("count jumped");
  // ========
  // scenario covers
  overflowSeen_c: cover property ($rose(overflowIrq));
  wakeSeen_c: cover property (wakeRequest);
  matchSeen_c: cover property (compareMatch);
endmodule // gated_16bit_timer_assertions

bind gated_16bit_timer gated_16bit_timer_assertions gated_16bit_timer_assertions_inst (
  .clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest,
  .crystalInputPin, .crystalOutputPin, .sleepMode, .autoConversionTrigger,
  .countRegister, .compareMatch, .overflowIrq, .wakeRequest);

// File: testbench/gate_source_model.sv
`timescale 1ns/1ps
module gate_source_model (
  // clock
  input wire logic clk,
  // run controls
  input wire logic runEight,
  input wire logic runExt,
  // far-side signals
  output logic [7:0] eightBitTimerCount,
  output logic externalClockPin
);
  // ========
  // companion counter and external clock, still when not run
  logic [7:0] eightCount_q = 8'hf8;
  logic [1:0] extDiv_q = 2'h0;
  always @(posedge clk) begin
    if (runEight) begin
      eightCount_q <= eightCount_q + 8'h01;
    end
    extDiv_q <= runExt ? extDiv_q + 2'h1 : 2'h0;
  end
  assign eightBitTimerCount = eightCount_q;
  assign externalClockPin = extDiv_q[1];
endmodule // gate_source_model

// File: testbench/gated_16bit_timer_test.sv
`timescale 1ns/1ps
`include "gated_timer_consts.svh"
module gated_16bit_timer_test;
  import gated_timer_pkg::*;
  // ========
  // signals
  localparam logic [4:0] TC = `OFF_TIMER_CONTROL;
  localparam logic [4:0] GC = `OFF_GATE_CONTROL;
  localparam logic [4:0] CL = `OFF_COUNT_LOW;
  localparam logic [4:0] CH = `OFF_COUNT_HIGH;
  localparam logic [4:0] FL = `OFF_FLAGS;
  localparam logic [4:0] EN = `OFF_ENABLES;
  localparam logic [4:0] CC = `OFF_CAPTURE_COMPARE;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [`ADDR_W-1:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  gate_inputs_s gateInputs = 3'h0;
  logic [7:0] eightBitTimerCount;
  logic externalClockPin;
  logic crystalInputPin = 1'b0;
  logic crystalOutputPin;
  logic sleepMode = 1'b0;
  logic captureEvent = 1'b0;
  logic autoConversionTrigger = 1'b0;
  logic [15:0] countRegister;
  logic compareMatch;
  logic overflowIrq;
  logic gateEventIrq;
  logic wakeRequest;
  logic runEight = 1'b0;
  logic runExt = 1'b0;
  int mismatches = 0;
  int nTests = 0;
  gated_16bit_timer gated_16bit_timer_inst (.clk, .reset, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .gateInputs, .eightBitTimerCount,
    .externalClockPin, .crystalInputPin, .crystalOutputPin, .sleepMode, .captureEvent,
    .autoConversionTrigger, .countRegister, .compareMatch, .overflowIrq, .gateEventIrq,
    .wakeRequest);
  gate_source_model gate_source_model_inst (.clk, .runEight, .runExt,
    .eightBitTimerCount, .externalClockPin);
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ========
  // shared tasks
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= w;
    read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    autoConversionTrigger <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q & {16'h0000, m}, {16'h0000, e});
  endtask
  task automatic pulse(input int h, input int l);
    gateInputs <= 3'h4;
    repeat (h) @(posedge clk);
    gateInputs <= 3'h0;
    repeat (l) @(posedge clk);
  endtask
  // ========
  // scenarios
  task automatic s_regs();
    rdc(TC, 16'h00ff, 16'h0000);
    rdc(GC, 16'h00fb, 16'h0000);
    wr(5'h1c, 8'hff);
    rdc(5'h1c, 16'hffff, 16'h0000);
    wr(TC, 8'h0a);
    rdc(TC, 16'h00ff, 16'h0008);
    check(crystalOutputPin, 1'b1);
  endtask
  task automatic s_clocks();
    logic [31:0] q;
    int e;
    int t;
    runExt <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 4; p++) begin
        wr(TC, 8'h00);
        wr(CL, 8'h00);
        wr(TC, 8'(c * 64 + p * 16 + 1));
        repeat (120) @(posedge clk);
        wr(TC, 8'h00);
        bus(1'b0, CL, 8'h00, q);
        e = c == 3 ? 0 : 123 / ((c == 1 ? 1 : 4) << p);
        t = c == 3 ? 0 : 2;
        check(int'(q[7:0]) >= e - t && int'(q[7:0]) <= e + t, 1'b1);
      end
    end
    runExt <= 1'b0;
  endtask
  task automatic s_sources();
    // comparator two through the resynchronised path
    wr(EN, 8'h08);
    for (int s = 0; s < 4; s++) begin
      wr(GC, 8'h40 | 8'(s));
      wr(FL, 8'h03);
      if (s == 1) begin
        runEight <= 1'b1;
        repeat (300) @(posedge clk);
        runEight <= 1'b0;
      end else begin
        gateInputs <= 3'(4 >> (s > 0 ? s - 1 : 0));
        repeat (8) @(posedge clk);
        rdc(GC, 16'h0004, 16'h0004);
        gateInputs <= 3'h0;
      end
      repeat (8) @(posedge clk);
      rdc(FL, 16'h0002, 16'h0002);
    end
    wr(EN, 8'h02);
    @(posedge clk);
    check(gateEventIrq, 1'b1);
    wr(FL, 8'h02);
    @(posedge clk);
    check(gateEventIrq, 1'b0);
    wr(EN, 8'h00);
  endtask
  task automatic s_gating();
    logic [31:0] q;
    logic [31:0] r;
    wr(GC, 8'hc0);
    wr(CL, 8'h00);
    wr(TC, 8'h41);
    repeat (40) @(posedge clk);
    rdc(CL, 16'h00ff, 16'h0000);
    wr(GC, 8'h80);
    wr(TC, 8'h40);
    bus(1'b0, CL, 8'h00, q);
    check(q[7:0] != 8'h00, 1'b1);
    repeat (20) @(posedge clk);
    bus(1'b0, CL, 8'h00, r);
    check(r, q);
  endtask
  task automatic s_pulse();
    logic [31:0] q;
    wr(GC, 8'hd0);
    wr(GC, 8'hd8);
    wr(CL, 8'h00);
    wr(TC, 8'h41);
    pulse(20, 10);
    bus(1'b0, CL, 8'h00, q);
    check(q[7:0] >= 8'h12 && q[7:0] <= 8'h16, 1'b1);
    rdc(GC, 16'h0008, 16'h0000);
    pulse(20, 10);
    rdc(CL, 16'h00ff, {8'h00, q[7:0]});
    wr(GC, 8'hc0);
    wr(GC, 8'he0);
    wr(GC, 8'hf0);
    wr(GC, 8'hf8);
    wr(CL, 8'h00);
    pulse(10, 10);
    pulse(10, 10);
    bus(1'b0, CL, 8'h00, q);
    check(q[7:0] >= 8'h12 && q[7:0] <= 8'h16, 1'b1);
    wr(TC, 8'h00);
    wr(GC, 8'h00);
  endtask
  task automatic s_overflow();
    wr(EN, 8'h01);
    wr(CL, 8'hf8);
    wr(CH, 8'hff);
    wr(FL, 8'h03);
    sleepMode <= 1'b1;
    runExt <= 1'b1;
    wr(TC, 8'h85);
    repeat (60) @(posedge clk);
    check(wakeRequest, 1'b1);
    check(overflowIrq, 1'b1);
    sleepMode <= 1'b0;
    runExt <= 1'b0;
    rdc(FL, 16'h0001, 16'h0001);
    wr(FL, 8'h01);
    @(posedge clk);
    check(overflowIrq, 1'b0);
    wr(TC, 8'h00);
    wr(CL, 8'hfe);
    wr(CH, 8'hff);
    // running: trigger lands on the very edge that would wrap
    wr(TC, 8'h41);
    autoConversionTrigger <= 1'b1;
    @(posedge clk);
    autoConversionTrigger <= 1'b0;
    @(posedge clk);
    check(countRegister, 32'h0000_0000);
    rdc(FL, 16'h0001, 16'h0000);
    wr(TC, 8'h00);
  endtask
  task automatic s_capture();
    wr(CL, 8'h34);
    wr(CH, 8'h12);
    captureEvent <= 1'b1;
    @(posedge clk);
    captureEvent <= 1'b0;
    @(posedge clk);
    rdc(CC, 16'hffff, 16'h1234);
    check(compareMatch, 1'b1);
    autoConversionTrigger <= 1'b1;
    wr(CL, 8'h55);
    rdc(CL, 16'h00ff, 16'h0055);
  endtask
  // ========
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    s_regs();
    s_clocks();
    s_sources();
    s_gating();
    s_pulse();
    s_overflow();
    s_capture();
    finish_test();
  end
endmodule // gated_16bit_timer_test
